// file: cswc_top.sv
// selective wake configuration registers with serial link and wake control logic
`timescale 1ns/1ps
`default_nettype none

module cswc_top (
	input wire logic clk_i, // system clock, 200 MHz
	input wire logic rst_i, // synchronous reset, active high
	input wire logic sclk_i, // serial link clock
	input wire logic csn_n_i, // serial frame select, active low
	input wire logic mosi_i, // serial data from controller
	output logic miso_o, // serial data to controller
	output logic miso_oe_o, // miso output enable
	input wire logic can_transmit_data_pin_i, // transmit data pin, trim pattern
	input wire cswc_pkg::cswc_opmode_t op_mode_i, // chip operating mode
	input wire logic selective_wake_mode_i, // selective wake mode bit
	input wire logic wake_event_i, // wake-up detected, one-cycle pulse
	input wire logic bus_timeout_event_i, // bus timeout seen, one-cycle pulse
	input wire logic bus_timeout_clear_i, // bus status flag clear pulse
	input wire logic can_config_write_i, // write to a can config register
	output logic bus_timeout_flag_o, // bus timeout status bit
	output logic bus_timeout_irq_o, // timeout interrupt pulse
	output logic selective_wake_active_o, // selective wake enabled
	output logic osc_calibration_active_o, // calibration on and unlocked
	output logic trim_edge_o, // sync edge from transmit pin pulse
	output logic alt_receiver_enable_o, // low-power wake receiver on
	output cswc_pkg::cswc_config_t config_o // bit timing and wake frame
);

	// ****************************************
	// link domain front end
	// ****************************************
	cswc_pkg::cswc_frame_t link_frame;
	logic link_tgl;
	logic [15:0] resp_ff;

	cswc_link_rx u_link (
		.sclk_i(sclk_i),
		.csn_n_i(csn_n_i),
		.mosi_i(mosi_i),
		.rst_i(rst_i),
		.resp_i(resp_ff),
		.frame_o(link_frame),
		.frame_tgl_o(link_tgl),
		.miso_o(miso_o),
		.miso_oe_o(miso_oe_o)
	);

	// ****************************************
	// frame toggle crossing
	// ****************************************
	logic tgl_s1_ff;
	logic tgl_s2_ff;
	logic tgl_s3_ff;
	logic tgl_seen_ff;
	logic frame_evt;

	// three stages; a toggle counts once the last two agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tgl_s1_ff <= 1'b0;
			tgl_s2_ff <= 1'b0;
			tgl_s3_ff <= 1'b0;
		end else begin
			tgl_s1_ff <= link_tgl;
			tgl_s2_ff <= tgl_s1_ff;
			tgl_s3_ff <= tgl_s2_ff;
		end
	end

	// remember the last accepted toggle level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tgl_seen_ff <= 1'b0;
		end else if (frame_evt) begin
			tgl_seen_ff <= tgl_s3_ff;
		end
	end

	// frame word is stable: it only moves on the next frame's last edge
	assign frame_evt = (tgl_s2_ff == tgl_s3_ff) && (tgl_s3_ff != tgl_seen_ff);

	// ****************************************
	// register storage
	// ****************************************
	logic [7:0] wake_ctrl_ff;
	logic cfg_valid_ff;
	logic [7:0] quanta_ff;
	logic [7:0] sample_ff;
	logic [7:0] id_high_ff;
	logic [7:0] id_umid_ff;
	logic [7:0] id_lmid_ff;
	logic [7:0] id_low_ff;
	logic [7:0] wake_opt_ff;
	logic wr_evt;
	logic [7:0] wdata;
	logic unlocked;

	assign wr_evt = frame_evt && link_frame.write;
	assign wdata = link_frame.data;
	assign unlocked = (wake_ctrl_ff[cswc_pkg::KEY_HI:cswc_pkg::KEY_LO]
		== cswc_pkg::KEY_UNLOCK);

	// wake control; reserved bits never stored, config valid kept apart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_ctrl_ff <= cswc_pkg::RST_WAKE_CTRL;
		end else if (wr_evt && link_frame.addr == cswc_pkg::ADDR_WAKE_CTRL) begin
			wake_ctrl_ff <= wdata & cswc_pkg::MASK_WAKE_CTRL & ~8'h01;
		end
	end

	// quanta per bit, full byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			quanta_ff <= cswc_pkg::RST_QUANTA;
		end else if (wr_evt && link_frame.addr == cswc_pkg::ADDR_QUANTA) begin
			quanta_ff <= wdata;
		end
	end

	// sample point fraction, top two bits dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_ff <= cswc_pkg::RST_SAMPLE;
		end else if (wr_evt && link_frame.addr == cswc_pkg::ADDR_SAMPLE) begin
			sample_ff <= wdata & cswc_pkg::MASK_SAMPLE;
		end
	end

	// identifier bits 28 to 21
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			id_high_ff <= cswc_pkg::RST_ID;
		end else if (wr_evt && link_frame.addr == cswc_pkg::ADDR_ID_HIGH) begin
			id_high_ff <= wdata;
		end
	end

	// identifier bits 20 to 13
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			id_umid_ff <= cswc_pkg::RST_ID;
		end else if (wr_evt && link_frame.addr == cswc_pkg::ADDR_ID_UMID) begin
			id_umid_ff <= wdata;
		end
	end

	// identifier bits 12 to 5
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			id_lmid_ff <= cswc_pkg::RST_ID;
		end else if (wr_evt && link_frame.addr == cswc_pkg::ADDR_ID_LMID) begin
			id_lmid_ff <= wdata;
		end
	end

	// identifier bits 4 to 0 plus frame type and length flags; bit 7 dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			id_low_ff <= cswc_pkg::RST_ID;
		end else if (wr_evt && link_frame.addr == cswc_pkg::ADDR_ID_LOW) begin
			id_low_ff <= wdata & cswc_pkg::MASK_ID_LOW;
		end
	end

	// wake option writes pass only with the key at 11; a locked write is dropped silently
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_opt_ff <= cswc_pkg::RST_WAKE_OPT;
		end else if (wr_evt && link_frame.addr == cswc_pkg::ADDR_WAKE_OPT && unlocked) begin
			wake_opt_ff <= wdata & cswc_pkg::MASK_WAKE_OPT;
		end
	end

	// ****************************************
	// configuration valid handling
	// ****************************************
	logic cfg_addr;
	logic data_addr;
	logic [7:0] cur_data;
	logic [7:0] cur_mask;
	logic cfg_change;
	logic stop_write;
	logic nxt_cfg_valid;

	// current contents of a configuration data register, for change detection
	always_comb begin
		cur_data = cswc_pkg::BYTE_ZERO;
		cur_mask = cswc_pkg::BYTE_ZERO;
		data_addr = 1'b1;
		if (link_frame.addr == cswc_pkg::ADDR_QUANTA) begin
			cur_data = quanta_ff;
			cur_mask = cswc_pkg::MASK_FULL;
		end else if (link_frame.addr == cswc_pkg::ADDR_SAMPLE) begin
			cur_data = sample_ff;
			cur_mask = cswc_pkg::MASK_SAMPLE;
		end else if (link_frame.addr == cswc_pkg::ADDR_ID_HIGH) begin
			cur_data = id_high_ff;
			cur_mask = cswc_pkg::MASK_FULL;
		end else if (link_frame.addr == cswc_pkg::ADDR_ID_UMID) begin
			cur_data = id_umid_ff;
			cur_mask = cswc_pkg::MASK_FULL;
		end else if (link_frame.addr == cswc_pkg::ADDR_ID_LMID) begin
			cur_data = id_lmid_ff;
			cur_mask = cswc_pkg::MASK_FULL;
		end else if (link_frame.addr == cswc_pkg::ADDR_ID_LOW) begin
			cur_data = id_low_ff;
			cur_mask = cswc_pkg::MASK_ID_LOW;
		end else if (link_frame.addr == cswc_pkg::ADDR_WAKE_OPT) begin
			// a locked write is dropped, so it must not count as a change either
			cur_data = unlocked ? wake_opt_ff : cswc_pkg::BYTE_ZERO;
			cur_mask = unlocked ? cswc_pkg::MASK_WAKE_OPT : cswc_pkg::BYTE_ZERO;
		end else begin
			data_addr = 1'b0;
		end
	end

	// a rewrite of the same value is no change and leaves validity alone
	assign cfg_change = wr_evt && data_addr && ((wdata & cur_mask) != cur_data);
	assign cfg_addr = data_addr || (link_frame.addr == cswc_pkg::ADDR_WAKE_CTRL);
	assign stop_write = (op_mode_i == cswc_pkg::MODE_STOP)
		&& ((wr_evt && cfg_addr) || can_config_write_i);

	// hardware clears outrank a software set in the same cycle
	always_comb begin
		nxt_cfg_valid = cfg_valid_ff;
		if (wake_event_i || cfg_change || stop_write) begin
			nxt_cfg_valid = 1'b0;
		end else if (wr_evt && link_frame.addr == cswc_pkg::ADDR_WAKE_CTRL) begin
			nxt_cfg_valid = wdata[cswc_pkg::BIT_CFG_VALID];
		end
	end

	// validity register, cleared at reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_valid_ff <= 1'b0;
		end else begin
			cfg_valid_ff <= nxt_cfg_valid;
		end
	end

	// ****************************************
	// wake control effects
	// ****************************************
	logic sw_active_ff;
	logic osc_active_ff;
	logic timeout_flag_ff;
	logic irq_ff;
	logic mode_ok;

	// selective wake runs only with the mode bit and a valid configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_active_ff <= 1'b0;
		end else begin
			sw_active_ff <= cfg_valid_ff && selective_wake_mode_i;
		end
	end

	// calibration needs both the enable bit and the unlock key
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_active_ff <= 1'b0;
		end else begin
			osc_active_ff <= wake_ctrl_ff[cswc_pkg::BIT_OSC_CALIBRATION_ENABLE] && unlocked;
		end
	end

	// status flag: set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timeout_flag_ff <= 1'b0;
		end else if (bus_timeout_event_i && selective_wake_mode_i) begin
			timeout_flag_ff <= 1'b1;
		end else if (bus_timeout_clear_i) begin
			timeout_flag_ff <= 1'b0;
		end
	end

	assign mode_ok = (op_mode_i == cswc_pkg::MODE_NORMAL) || (op_mode_i == cswc_pkg::MODE_STOP);

	// interrupt pulse one cycle after a qualifying timeout
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= bus_timeout_event_i && selective_wake_mode_i && mode_ok
				&& wake_ctrl_ff[cswc_pkg::BIT_TIMEOUT_IRQ];
		end
	end

	// ****************************************
	// trim pattern from the transmit pin
	// ****************************************
	logic txd_s1_ff;
	logic txd_s2_ff;
	logic txd_s3_ff;
	logic txd_level_ff;
	logic trim_ff;
	logic txd_change;

	// pin synchroniser, first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txd_s1_ff <= 1'b0;
			txd_s2_ff <= 1'b0;
			txd_s3_ff <= 1'b0;
		end else begin
			txd_s1_ff <= can_transmit_data_pin_i;
			txd_s2_ff <= txd_s1_ff;
			txd_s3_ff <= txd_s2_ff;
		end
	end

	assign txd_change = (txd_s2_ff == txd_s3_ff) && (txd_s3_ff != txd_level_ff);

	// accepted pin level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txd_level_ff <= 1'b0;
		end else if (txd_change) begin
			txd_level_ff <= txd_s3_ff;
		end
	end

	// edges only matter while trimming is on; otherwise the pin is normal traffic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trim_ff <= 1'b0;
		end else begin
			trim_ff <= txd_change && osc_active_ff;
		end
	end

	// ****************************************
	// read back and answer word
	// ****************************************
	logic [7:0] rdata;
	logic [7:0] status;

	// reserved bits are never stored, so they read back zero
	always_comb begin
		rdata = cswc_pkg::BYTE_ZERO;
		if (link_frame.addr == cswc_pkg::ADDR_WAKE_CTRL) begin
			rdata = wake_ctrl_ff;
			rdata[cswc_pkg::BIT_CFG_VALID] = cfg_valid_ff;
		end else if (data_addr) begin
			rdata = (link_frame.addr == cswc_pkg::ADDR_WAKE_OPT) ? wake_opt_ff : cur_data;
		end
	end

	// status byte sent ahead of the data byte
	always_comb begin
		status = cswc_pkg::BYTE_ZERO;
		status[cswc_pkg::ST_CFG_VALID] = cfg_valid_ff;
		status[cswc_pkg::ST_TIMEOUT] = timeout_flag_ff;
	end

	// answer captured per frame; it shows the addressed byte before any write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_ff <= '0;
		end else if (frame_evt) begin
			resp_ff <= {status, rdata};
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign bus_timeout_flag_o = timeout_flag_ff;
	assign bus_timeout_irq_o = irq_ff;
	assign selective_wake_active_o = sw_active_ff;
	assign osc_calibration_active_o = osc_active_ff;
	assign trim_edge_o = trim_ff;
	assign alt_receiver_enable_o = wake_opt_ff[cswc_pkg::BIT_ALT_RX];

	// identifier assembled in order high to low
	assign config_o.quanta_per_bit = quanta_ff;
	assign config_o.sample_point_fraction = sample_ff[cswc_pkg::SP_HI:0];
	assign config_o.wake_id = {id_high_ff, id_umid_ff, id_lmid_ff,
		id_low_ff[cswc_pkg::ID_LOW_HI:cswc_pkg::ID_LOW_LO]};
	assign config_o.remote_request = id_low_ff[cswc_pkg::BIT_RTR];
	assign config_o.extended_id = id_low_ff[cswc_pkg::BIT_IDE];

endmodule

`default_nettype wire

// file: cswc_pkg.sv
// constants, field layouts and carrier types of the selective wake configuration block
//
// Notes on behaviour
// - wake control bit 7 set turns oscillator calibration on, clear turns it off.
// - unlock key bits 6:5 unlock recalibration only at binary 11.
// - during trimming the oscillator is synced from edges on the transmit data pin.
// - wake option register writes are taken only while the unlock key reads 11.
// - wake control bit 4 clear masks bus timeout interrupts, set reports them.
// - bus timeout flag updates only while the selective wake mode bit is set; the code gates only the set, bus_timeout_clear_i clears it in any mode.
// - timeout interrupt only with selective wake on, in normal or stop mode.
// - controller sets config valid bit 0; selective wake runs only while it is 1.
// - config valid clears on wake event, reset, or changed wake configuration data.
// - in stop mode any configuration register write forces config valid to 0.
// - reserved bits of wake control, sample point and low identifier read zero.
// - 8-bit quanta per bit field, reset value 0xa0.
// - 6-bit sample point fraction at bits 5:0, reset value 0x33.
// - identifier bits 28:0 spread over four registers, low five at bits 6:2.
// - low identifier bit 1 selects remote request (1) or data frame (0).
// - low identifier bit 0 selects 29-bit extended (1) or 11-bit identifier (0).
`default_nettype none

package cswc_pkg;

	// ****************************************
	// link frame geometry
	// ****************************************
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int FRAME_W = 16;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [3:0] FRAME_MSB = 4'hf;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [6:0] ADDR_WAKE_CTRL = 7'h20;
	localparam logic [6:0] ADDR_QUANTA = 7'h21;
	localparam logic [6:0] ADDR_SAMPLE = 7'h22;
	localparam logic [6:0] ADDR_ID_HIGH = 7'h23;
	localparam logic [6:0] ADDR_ID_UMID = 7'h24;
	localparam logic [6:0] ADDR_ID_LMID = 7'h25;
	localparam logic [6:0] ADDR_ID_LOW = 7'h26;
	localparam logic [6:0] ADDR_WAKE_OPT = 7'h35;

	// ****************************************
	// reset values and writable bit masks
	// ****************************************
	localparam logic [7:0] RST_WAKE_CTRL = 8'h00;
	localparam logic [7:0] RST_QUANTA = 8'ha0;
	localparam logic [7:0] RST_SAMPLE = 8'h33;
	localparam logic [7:0] RST_ID = 8'h00;
	localparam logic [7:0] RST_WAKE_OPT = 8'h00;
	localparam logic [7:0] MASK_WAKE_CTRL = 8'hf1;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_SAMPLE = 8'h3f;
	localparam logic [7:0] MASK_ID_LOW = 8'h7f;
	localparam logic [7:0] MASK_WAKE_OPT = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_OSC_CALIBRATION_ENABLE = 7;
	localparam int KEY_HI = 6;
	localparam int KEY_LO = 5;
	localparam logic [1:0] KEY_UNLOCK = 2'h3;
	localparam int BIT_TIMEOUT_IRQ = 4;
	localparam int BIT_CFG_VALID = 0;
	localparam int SP_HI = 5;
	localparam int ID_LOW_HI = 6;
	localparam int ID_LOW_LO = 2;
	localparam int BIT_RTR = 1;
	localparam int BIT_IDE = 0;
	localparam int BIT_ALT_RX = 0;
	localparam int ST_CFG_VALID = 7;
	localparam int ST_TIMEOUT = 6;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cswc_frame_t;

	typedef struct packed {
		logic [7:0] quanta_per_bit;
		logic [5:0] sample_point_fraction;
		logic [28:0] wake_id;
		logic remote_request;
		logic extended_id;
	} cswc_config_t;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_STOP = 2'h1,
		MODE_SLEEP = 2'h2,
		MODE_OTHER = 2'h3
	} cswc_opmode_t;

endpackage

`default_nettype wire

// file: cswc_link_rx.sv
// serial register link front end, clocked by the link's own serial clock
`timescale 1ns/1ps
`default_nettype none

module cswc_link_rx (
	input wire logic sclk_i, // serial clock from the controller
	input wire logic csn_n_i, // frame select, low during a frame
	input wire logic mosi_i, // serial data in, msb first
	input wire logic rst_i, // block reset, asynchronous here
	input wire logic [15:0] resp_i, // answer word, steady during a frame
	output cswc_pkg::cswc_frame_t frame_o, // last complete frame
	output logic frame_tgl_o, // toggles once per complete frame
	output logic miso_o, // serial data out
	output logic miso_oe_o // high while miso is driven
);

	logic [4:0] cnt_ff;
	logic [15:0] shreg_ff;
	cswc_pkg::cswc_frame_t frame_ff;
	logic tgl_ff;

	// bit counter is cleared by the frame select itself, since sclk stops between frames
	always_ff @(posedge sclk_i or posedge csn_n_i) begin
		if (csn_n_i) begin
			cnt_ff <= 5'h00;
		end else if (cnt_ff != cswc_pkg::FRAME_BITS) begin
			cnt_ff <= cnt_ff + 5'h01;
		end
	end

	// input shifter
	always_ff @(posedge sclk_i) begin
		shreg_ff <= {shreg_ff[14:0], mosi_i};
	end

	// only an exact sixteenth edge completes a frame; extra clocks are ignored
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_ff <= '0;
			tgl_ff <= 1'b0;
		end else if (cnt_ff == cswc_pkg::FRAME_BITS - 5'h01) begin
			frame_ff <= {shreg_ff[14:0], mosi_i};
			tgl_ff <= ~tgl_ff;
		end
	end

	// answer bits follow the counter; the word is held still in the other domain
	assign miso_o = (cnt_ff < cswc_pkg::FRAME_BITS) ?
		resp_i[cswc_pkg::FRAME_MSB - cnt_ff[3:0]] : 1'b0;
	assign miso_oe_o = ~csn_n_i;
	assign frame_o = frame_ff;
	assign frame_tgl_o = tgl_ff;

endmodule

`default_nettype wire

// file: cswc_top_asserts.sv
// concurrent checks on the ports of the selective wake configuration block
`timescale 1ns/1ps
`default_nettype none
module cswc_top_asserts (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset
	input wire cswc_pkg::cswc_opmode_t op_mode_i, // chip mode
	input wire logic selective_wake_mode_i, // wake mode bit
	input wire logic wake_event_i, // wake pulse
	input wire logic bus_timeout_event_i, // timeout pulse
	input wire logic can_config_write_i, // config write pulse
	input wire logic bus_timeout_flag_o, // timeout flag
	input wire logic bus_timeout_irq_o, // timeout irq
	input wire logic selective_wake_active_o, // wake active
	input wire logic osc_calibration_active_o, // calibration on
	input wire logic trim_edge_o, // trim pulse
	input wire cswc_pkg::cswc_config_t config_o // configuration
);
	// ******
	// properties, all in the system clock domain
	// ******
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_irq;
		bus_timeout_irq_o |-> $past(bus_timeout_event_i) && $past(selective_wake_mode_i)
			&& ($past(op_mode_i) == cswc_pkg::MODE_NORMAL || $past(op_mode_i) == cswc_pkg::MODE_STOP);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");
	property p_rst;
		$fell(rst_i) |-> config_o.quanta_per_bit == 8'ha0
			&& config_o.sample_point_fraction == 6'h33 && config_o.wake_id == 29'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset config");
	property p_wake;
		wake_event_i |-> ##2 !selective_wake_active_o;
	endproperty
	a_wake: assert property (p_wake) else $error("active after wake");
	property p_stop;
		op_mode_i == cswc_pkg::MODE_STOP && can_config_write_i |-> ##2 !selective_wake_active_o;
	endproperty
	a_stop: assert property (p_stop) else $error("active after stop write");
	property p_act;
		selective_wake_active_o |-> $past(selective_wake_mode_i);
	endproperty
	a_act: assert property (p_act) else $error("active without mode");
	property p_trim;
		trim_edge_o |-> $past(osc_calibration_active_o);
	endproperty
	a_trim: assert property (p_trim) else $error("trim while off");
	property p_fset;
		bus_timeout_event_i && selective_wake_mode_i |=> bus_timeout_flag_o;
	endproperty
	a_fset: assert property (p_fset) else $error("flag not set");
	property p_frise;
		$rose(bus_timeout_flag_o) |-> $past(bus_timeout_event_i) && $past(selective_wake_mode_i);
	endproperty
	a_frise: assert property (p_frise) else $error("flag rose without cause");
endmodule
bind cswc_top cswc_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .op_mode_i(op_mode_i),
	.selective_wake_mode_i(selective_wake_mode_i), .wake_event_i(wake_event_i),
	.bus_timeout_event_i(bus_timeout_event_i), .can_config_write_i(can_config_write_i),
	.bus_timeout_flag_o(bus_timeout_flag_o), .bus_timeout_irq_o(bus_timeout_irq_o),
	.selective_wake_active_o(selective_wake_active_o),
	.osc_calibration_active_o(osc_calibration_active_o), .trim_edge_o(trim_edge_o),
	.config_o(config_o));
`default_nettype wire

// file: cswc_host_model.sv
// controller model driving 16-bit register frames over the serial link
`timescale 1ns/1ps
`default_nettype none
module cswc_host_model (
	output logic sclk_o, // link clock, still between frames
	output logic csn_n_o, // frame select, active low
	output logic mosi_o, // data to the block
	input wire logic miso_i, // data from the block
	input wire logic miso_oe_i // block drives miso
);
	// ******
	// frame engine, 12 ns link period
	// ******
	initial begin
		sclk_o = 1'b0;
		csn_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// msb first; returns the answer of the previous frame
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		int i;
		r = 16'h0000;
		csn_n_o = 1'b0;
		for (i = 15; i >= 0; i--) begin
			mosi_o = w[i];
			#6;
			r[i] = miso_oe_i ? miso_i : 1'bx;
			sclk_o = 1'b1;
			#6;
			sclk_o = 1'b0;
		end
		#6;
		csn_n_o = 1'b1;
		mosi_o = ~mosi_o; // released line must not show the last bit
		#60; // gap also lets the system side take the frame
	endtask
endmodule
`default_nettype wire

// file: cswc_top_tb.sv
// self-checking bench for the selective wake configuration block
`timescale 1ns/1ps
`default_nettype none
module cswc_top_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sclk, csn_n, mosi, miso, miso_oe, to_flag, to_irq, sw_act, osc_act, trim, alt_rx;
	logic pin = 1'b0;
	logic swm = 1'b0;
	logic wake_ev = 1'b0;
	logic to_ev = 1'b0;
	logic to_clr = 1'b0;
	logic cfg_wr = 1'b0;
	cswc_pkg::cswc_opmode_t op_mode = cswc_pkg::MODE_NORMAL;
	cswc_pkg::cswc_config_t cfg;
	int mismatches = 0;
	int compares = 0;
	always #2.5 clk_i = ~clk_i;
	cswc_host_model host (.sclk_o(sclk), .csn_n_o(csn_n), .mosi_o(mosi), .miso_i(miso),
		.miso_oe_i(miso_oe));
	cswc_top dut (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .csn_n_i(csn_n), .mosi_i(mosi),
		.miso_o(miso), .miso_oe_o(miso_oe), .can_transmit_data_pin_i(pin), .op_mode_i(op_mode),
		.selective_wake_mode_i(swm), .wake_event_i(wake_ev), .bus_timeout_event_i(to_ev),
		.bus_timeout_clear_i(to_clr), .can_config_write_i(cfg_wr), .bus_timeout_flag_o(to_flag),
		.bus_timeout_irq_o(to_irq), .selective_wake_active_o(sw_act),
		.osc_calibration_active_o(osc_act), .trim_edge_o(trim), .alt_receiver_enable_o(alt_rx),
		.config_o(cfg));
	// ******
	// shared tasks
	// ******
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		host.xfer({1'b1, a, d}, r);
	endtask
	// read needs a second frame to carry the answer back
	task automatic rd(input logic [6:0] a, output logic [15:0] r);
		host.xfer({1'b0, a, 8'h00}, r);
		host.xfer({1'b0, 7'h7f, 8'h00}, r);
	endtask
	// one-cycle strobe: 0 wake, 1 config write, 2 flag clear, 3 timeout
	task automatic pulse(input int sel);
		@(posedge clk_i);
		wake_ev <= (sel == 0);
		cfg_wr <= (sel == 1);
		to_clr <= (sel == 2);
		to_ev <= (sel == 3);
		@(posedge clk_i);
		wake_ev <= 1'b0;
		cfg_wr <= 1'b0;
		to_clr <= 1'b0;
		to_ev <= 1'b0;
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ******
	// scenarios
	// ******
	task automatic t_reset;
		logic [7:0] rv [7] = '{8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [15:0] r;
		for (int i = 0; i < 7; i++) begin
			rd(7'h20 + 7'(i), r);
			chk(r[7:0], rv[i]);
		end
		$display("reset values done");
	endtask
	// reserved bits dropped, unmapped place reads zero
	task automatic t_regs;
		logic [6:0] a [5] = '{7'h20, 7'h21, 7'h22, 7'h26, 7'h7f};
		logic [7:0] w [5] = '{8'h0e, 8'h5a, 8'hff, 8'hfd, 8'h55};
		logic [7:0] x [5] = '{8'h00, 8'h5a, 8'h3f, 8'h7d, 8'h00};
		logic [28:0] id;
		logic [15:0] r;
		id = {11'h5a3, 18'h0};
		for (int i = 0; i < 5; i++) begin
			wr(a[i], w[i]);
			rd(a[i], r);
			chk(r[7:0], x[i]);
		end
		chk({cfg.quanta_per_bit, 2'b00, cfg.sample_point_fraction}, 16'h5a3f);
		chk({cfg.wake_id[4:0], cfg.remote_request, cfg.extended_id}, 7'h7d);
		wr(7'h23, id[28:21]);
		wr(7'h24, id[20:13]);
		wr(7'h25, id[12:5]);
		wr(7'h26, {1'b0, id[4:0], 2'b00});
		chk(cfg.wake_id, id);
		chk({cfg.remote_request, cfg.extended_id}, 2'b00);
		$display("register access done");
	endtask
	task automatic t_key;
		for (int k = 0; k < 4; k++) begin
			wr(7'h20, {1'b1, 2'(k), 5'h00});
			wr(7'h35, 8'h01);
			chk(osc_act, k == 3);
			chk(alt_rx, k == 3);
		end
		wr(7'h20, 8'h60);
		chk(osc_act, 1'b0);
		wr(7'h35, 8'h00);
		chk(alt_rx, 1'b0);
		$display("unlock key done");
	endtask
	// the bench plays the controller supplying the sync pattern
	task automatic t_trim;
		int n;
		for (int on = 1; on >= 0; on--) begin
			wr(7'h20, on ? 8'he0 : 8'h00);
			n = 0;
			repeat (4) begin
				@(posedge clk_i);
				pin <= ~pin;
				repeat (12) begin
					@(posedge clk_i);
					#1 n += int'(trim);
				end
			end
			chk(n, on ? 4 : 0);
		end
		$display("trim done");
	endtask
	task automatic t_cfg;
		logic [15:0] r;
		@(posedge clk_i);
		swm <= 1'b1;
		wr(7'h20, 8'h01);
		chk(sw_act, 1'b1);
		rd(7'h20, r);
		chk(r[15], 1'b1);
		wr(7'h21, 8'h5a);
		chk(sw_act, 1'b1);
		wr(7'h21, 8'ha5);
		chk(sw_act, 1'b0);
		wr(7'h20, 8'h01);
		pulse(0);
		repeat (3) @(posedge clk_i);
		chk(sw_act, 1'b0);
		wr(7'h20, 8'h01);
		@(posedge clk_i);
		op_mode <= cswc_pkg::MODE_STOP;
		pulse(1);
		repeat (3) @(posedge clk_i);
		chk(sw_act, 1'b0);
		wr(7'h20, 8'h01);
		chk(sw_act, 1'b0);
		@(posedge clk_i);
		op_mode <= cswc_pkg::MODE_NORMAL;
		wr(7'h20, 8'h01);
		@(posedge clk_i);
		swm <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(sw_act, 1'b0);
		wr(7'h20, 8'h00);
		$display("config valid done");
	endtask
	task automatic t_timeout;
		for (int m = 0; m < 2; m++) begin
			wr(7'h20, {3'b000, 1'(m), 4'h0});
			for (int s = 0; s < 2; s++) begin
				for (int o = 0; o < 4; o++) begin
					@(posedge clk_i);
					op_mode <= cswc_pkg::cswc_opmode_t'(o[1:0]);
					swm <= 1'(s);
					pulse(2);
					pulse(3);
					#1 chk(to_irq, s == 1 && o < 2 && m == 1);
					chk(to_flag, s == 1);
				end
			end
		end
		@(posedge clk_i);
		swm <= 1'b0;
		op_mode <= cswc_pkg::MODE_NORMAL;
		$display("bus timeout done");
	endtask
	// ******
	// main sequence and watchdog
	// ******
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_reset();
		t_regs();
		t_key();
		t_trim();
		t_cfg();
		t_timeout();
		report_and_stop();
	end
	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end
endmodule
`default_nettype wire
